// ==== logic/port_io_pkg.sv ====
// constants, register map and carrier types for the port and memory bus block
// assumes one system clock and a special function register access port
package port_io_pkg;
  localparam logic [7:0] bus_low_port_latch_addr        = 8'h80;
  localparam logic [7:0] port_one_latch_addr            = 8'h90;
  localparam logic [7:0] bus_high_port_latch_addr       = 8'ha0;
  localparam logic [7:0] port_three_latch_addr          = 8'hb0;
  localparam logic [7:0] compare_output_port_latch_addr = 8'hc0;
  localparam logic [7:0] internal_rom_size_select_addr  = 8'hc2;
  localparam logic [7:0] analog_port_latch_addr         = 8'hc4;
  localparam logic [7:0] pwm_adc_port_latch_addr        = 8'hf1;

  localparam logic [7:0] port_latch_reset       = 8'hff;
  localparam logic [2:0] rom_size_reset         = 3'h5;
  localparam logic [7:0] pwm_adc_implemented    = 8'hbf;
  localparam int         missing_port_bit       = 6;
  localparam logic [1:0] machine_cycle_clocks_m1 = 2'h3;
  localparam logic [1:0] addr_latch_phase       = 2'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       fetch;
    logic       data_wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ext_req_s;
endpackage

// ==== logic/port_io_and_memory_bus.sv ====
// port latches, pin drivers and multiplexed external memory bus
// assumes the cpu issues sfr accesses and external requests synchronous to i_sys_clk
`timescale 1ns/10ps
module port_io_and_memory_bus
  import port_io_pkg::*;
#(
  parameter int unsigned rom_bytes_max = 8192
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire sfr_req_s    i_sfr_req,
  output logic      [7:0]  o_sfr_rdata,
  input  wire ext_req_s    i_ext_req,
  input  wire logic        i_ext_req_valid,
  output logic             o_ext_req_ready,
  output logic      [7:0]  o_ext_rdata,
  output logic             o_ext_rdata_valid,
  output logic             o_fetch_external,
  input  wire logic [15:0] i_fetch_addr,
  input  wire logic        i_force_external_n,
  output logic             o_addr_latch_strobe,
  output logic             o_prog_fetch_strobe_n,
  output logic             o_data_rd_strobe_n,
  output logic             o_data_wr_strobe_n,
  input  wire logic [7:0]  i_bus_low_port,
  output logic      [7:0]  o_bus_low_port,
  output logic      [7:0]  o_bus_low_port_oe,
  input  wire logic [7:0]  i_bus_high_port,
  output logic      [7:0]  o_bus_high_port,
  output logic      [7:0]  o_bus_high_port_oe,
  input  wire logic [7:0]  i_port_one,
  output logic      [7:0]  o_port_one,
  output logic      [7:0]  o_port_one_oe,
  input  wire logic [7:0]  i_port_three,
  output logic      [7:0]  o_port_three,
  output logic      [7:0]  o_port_three_oe,
  input  wire logic [7:0]  i_compare_port,
  output logic      [7:0]  o_compare_port,
  output logic      [7:0]  o_compare_port_oe,
  input  wire logic [7:0]  i_analog_port_pins,
  output logic      [7:0]  o_analog_port_pins,
  output logic      [7:0]  o_analog_port_pins_oe,
  output logic      [7:0]  o_analog_in_ch,
  input  wire logic [7:0]  i_pwm_adc_port_pins,
  output logic      [7:0]  o_pwm_adc_port_pins,
  output logic      [7:0]  o_pwm_adc_port_pins_oe,
  input  wire logic [3:0]  i_pwm_out_ch,
  input  wire logic [3:0]  i_pwm_out_en,
  output logic             o_pwm_ext_clk_a,
  output logic             o_pwm_ext_clk_b,
  output logic             o_ext_conv_start_n
);

  //----------------------------------------------------------------
  // machine cycle phase
  //----------------------------------------------------------------
  logic [1:0] phase_reg;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_reg <= 2'h0;
    end else if (phase_reg == machine_cycle_clocks_m1) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  //----------------------------------------------------------------
  // port latches
  //----------------------------------------------------------------
  logic [7:0] bus_low_port_latch_reg;
  logic [7:0] port_one_latch_reg;
  logic [7:0] bus_high_port_latch_reg;
  logic [7:0] port_three_latch_reg;
  logic [7:0] compare_output_port_latch_reg;
  logic [2:0] internal_rom_size_reg;
  logic [7:0] analog_port_latch_reg;
  logic [7:0] pwm_adc_port_latch_reg;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_low_port_latch_reg        <= port_latch_reset;
      port_one_latch_reg            <= port_latch_reset;
      bus_high_port_latch_reg       <= port_latch_reset;
      port_three_latch_reg          <= port_latch_reset;
      compare_output_port_latch_reg <= port_latch_reset;
      internal_rom_size_reg         <= rom_size_reset;
      analog_port_latch_reg         <= port_latch_reset;
      pwm_adc_port_latch_reg        <= pwm_adc_implemented;
    end else if (i_sfr_req.wr) begin
      case (i_sfr_req.addr)
        bus_low_port_latch_addr:        bus_low_port_latch_reg <= i_sfr_req.wdata;
        port_one_latch_addr:            port_one_latch_reg <= i_sfr_req.wdata;
        bus_high_port_latch_addr:       bus_high_port_latch_reg <= i_sfr_req.wdata;
        port_three_latch_addr:          port_three_latch_reg <= i_sfr_req.wdata;
        compare_output_port_latch_addr: compare_output_port_latch_reg <= i_sfr_req.wdata;
        internal_rom_size_select_addr:  internal_rom_size_reg <= i_sfr_req.wdata[2:0];
        analog_port_latch_addr:         analog_port_latch_reg <= i_sfr_req.wdata;
        pwm_adc_port_latch_addr: begin
          pwm_adc_port_latch_reg <= i_sfr_req.wdata & pwm_adc_implemented;
        end
        default: begin
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // register read returns pin levels; rom size select reads back its register
  //----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_req.rd) begin
      case (i_sfr_req.addr)
        bus_low_port_latch_addr:        o_sfr_rdata <= i_bus_low_port;
        port_one_latch_addr:            o_sfr_rdata <= i_port_one;
        bus_high_port_latch_addr:       o_sfr_rdata <= i_bus_high_port;
        port_three_latch_addr:          o_sfr_rdata <= i_port_three;
        compare_output_port_latch_addr: o_sfr_rdata <= i_compare_port;
        internal_rom_size_select_addr:  o_sfr_rdata <= {5'h00, internal_rom_size_reg};
        analog_port_latch_addr:         o_sfr_rdata <= i_analog_port_pins;
        pwm_adc_port_latch_addr: begin
          o_sfr_rdata <= i_pwm_adc_port_pins & pwm_adc_implemented;
        end
        default:                        o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------
  // program fetch location
  //----------------------------------------------------------------
  logic [16:0] rom_limit;

  always_comb begin
    case (internal_rom_size_reg)
      3'h0:    rom_limit = 17'h0_0000;
      3'h1:    rom_limit = 17'h0_0400;
      3'h2:    rom_limit = 17'h0_0800;
      3'h3:    rom_limit = 17'h0_1000;
      3'h4:    rom_limit = 17'h0_2000;
      default: rom_limit = 17'(rom_bytes_max);
    endcase
  end

  // rom size changes are applied as written; software must avoid abrupt moves
  assign o_fetch_external = !i_force_external_n
                          || ({1'b0, i_fetch_addr} >= rom_limit);

  //----------------------------------------------------------------
  // external bus cycle: address out at phase 0, data at phases 1-3
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_addr  = 3'b010,
    st_data  = 3'b100
  } bus_state_e;

  bus_state_e bus_state_reg;
  ext_req_s   cur_reg;

  // requests taken only at the close of a machine cycle
  logic req_take;
  logic data_end;

  assign o_ext_req_ready = (bus_state_reg == st_idle) && (phase_reg == machine_cycle_clocks_m1);
  assign req_take        = i_ext_req_valid && o_ext_req_ready;
  assign data_end        = (bus_state_reg == st_data) && (phase_reg == machine_cycle_clocks_m1);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_state_reg <= st_idle;
    end else begin
      case (bus_state_reg)
        st_idle: begin
          if (req_take) begin
            bus_state_reg <= st_addr;
          end
        end
        st_addr: bus_state_reg <= st_data;
        st_data: begin
          if (data_end) begin
            bus_state_reg <= st_idle;
          end
        end
        default: bus_state_reg <= st_idle;
      endcase
    end
  end

  // request held for the whole bus cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_reg <= '0;
    end else if (req_take) begin
      cur_reg <= i_ext_req;
    end
  end

  // low port sampled at the close of the last data phase
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_rdata       <= 8'h00;
      o_ext_rdata_valid <= 1'b0;
    end else begin
      o_ext_rdata_valid <= data_end && !cur_reg.data_wr;
      if (data_end && !cur_reg.data_wr) begin
        o_ext_rdata <= i_bus_low_port;
      end
    end
  end

  wire bus_active = (bus_state_reg != st_idle);

  //----------------------------------------------------------------
  // bus strobes
  //----------------------------------------------------------------
  always_comb begin
    o_addr_latch_strobe   = (phase_reg == addr_latch_phase);
    o_prog_fetch_strobe_n = !((bus_state_reg == st_data) && cur_reg.fetch);
    o_data_rd_strobe_n    = !((bus_state_reg == st_data) && !cur_reg.fetch && !cur_reg.data_wr);
    o_data_wr_strobe_n    = !((bus_state_reg == st_data) && !cur_reg.fetch && cur_reg.data_wr);
  end

  //----------------------------------------------------------------
  // bus ports: memory bus while active, latch-driven i/o otherwise
  //----------------------------------------------------------------
  always_comb begin
    if (bus_active) begin
      o_bus_high_port    = cur_reg.addr[15:8];
      o_bus_high_port_oe = 8'hff;
      if (bus_state_reg == st_addr) begin
        o_bus_low_port    = cur_reg.addr[7:0];
        o_bus_low_port_oe = 8'hff;
      end else begin
        o_bus_low_port    = cur_reg.wdata;
        o_bus_low_port_oe = {8{cur_reg.data_wr && !cur_reg.fetch}};
      end
    end else begin
      o_bus_high_port    = 8'h00;
      o_bus_high_port_oe = ~bus_high_port_latch_reg;
      o_bus_low_port     = 8'h00;
      o_bus_low_port_oe  = ~bus_low_port_latch_reg;
    end
  end

  //----------------------------------------------------------------
  // general ports: drive low on zero, release on one
  //----------------------------------------------------------------
  always_comb begin
    o_port_one             = 8'h00;
    o_port_one_oe          = ~port_one_latch_reg;
    o_port_three           = 8'h00;
    o_port_three_oe        = ~port_three_latch_reg;
    o_compare_port         = 8'h00;
    o_compare_port_oe      = ~compare_output_port_latch_reg;
    o_analog_port_pins     = 8'h00;
    o_analog_port_pins_oe  = ~analog_port_latch_reg;
    o_analog_in_ch         = i_analog_port_pins;
  end

  //----------------------------------------------------------------
  // pwm and converter port
  //----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pwm_bit
      if (g == missing_port_bit) begin : g_absent
        assign o_pwm_adc_port_pins[g]    = 1'b0;
        assign o_pwm_adc_port_pins_oe[g] = 1'b0;
      end else if (g < 4) begin : g_pwm
        // enabled pwm channel takes the pin over from the latch
        wire use_pwm = i_pwm_out_en[g];
        assign o_pwm_adc_port_pins[g]    = use_pwm ? i_pwm_out_ch[g] : 1'b0;
        assign o_pwm_adc_port_pins_oe[g] = use_pwm | ~pwm_adc_port_latch_reg[g];
      end else begin : g_io
        assign o_pwm_adc_port_pins[g]    = 1'b0;
        assign o_pwm_adc_port_pins_oe[g] = ~pwm_adc_port_latch_reg[g];
      end
    end
  endgenerate

  assign o_pwm_ext_clk_a    = i_pwm_adc_port_pins[4];
  assign o_pwm_ext_clk_b    = i_pwm_adc_port_pins[5];
  assign o_ext_conv_start_n = i_pwm_adc_port_pins[7];

endmodule // port_io_and_memory_bus

// ==== tb/port_io_monitor.sv ====
// assertions on the port block pins and sfr port
// assumes binding into port_io_and_memory_bus
`timescale 1ns/10ps
module port_io_monitor
  import port_io_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_reset_n,
  input wire sfr_req_s   i_sfr_req,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_fetch_external,
  input wire logic       i_force_external_n,
  input wire logic       o_addr_latch_strobe,
  input wire logic       o_prog_fetch_strobe_n,
  input wire logic       o_data_rd_strobe_n,
  input wire logic [7:0] o_bus_low_port_oe,
  input wire logic [7:0] o_bus_high_port_oe,
  input wire logic [7:0] i_analog_port_pins,
  input wire logic [7:0] o_analog_port_pins,
  input wire logic [7:0] o_analog_port_pins_oe,
  input wire logic [7:0] o_analog_in_ch,
  input wire logic [7:0] i_pwm_adc_port_pins,
  input wire logic [7:0] o_pwm_adc_port_pins_oe,
  input wire logic       o_pwm_ext_clk_a,
  input wire logic       o_pwm_ext_clk_b,
  input wire logic       o_ext_conv_start_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  AST_ALE_PERIOD: assert property ($rose(o_addr_latch_strobe) |=>
    !o_addr_latch_strobe [*3] ##1 o_addr_latch_strobe) else $error("strobe period");
  AST_FETCH_LOW: assert property ($fell(o_prog_fetch_strobe_n) |->
    !o_prog_fetch_strobe_n [*3] ##1 o_prog_fetch_strobe_n) else $error("fetch strobe");
  AST_FORCE_EXT: assert property (!i_force_external_n |-> o_fetch_external)
    else $error("force ignored");
  AST_AN_WRITE: assert property (i_sfr_req.wr && i_sfr_req.addr == 8'hc4 |=>
    o_analog_port_pins_oe == ~$past(i_sfr_req.wdata)) else $error("analog latch");
  AST_AN_READ: assert property (i_sfr_req.rd && i_sfr_req.addr == 8'hc4 |=>
    o_sfr_rdata == $past(i_analog_port_pins)) else $error("pin read");
  AST_AN_NO_HIGH: assert property (o_analog_port_pins == 8'h00)
    else $error("analog drives high");
  AST_AN_CH: assert property (o_analog_in_ch == i_analog_port_pins)
    else $error("channel map");
  AST_BIT6: assert property (!o_pwm_adc_port_pins_oe[6])
    else $error("bit six driven");
  AST_CONV: assert property (o_ext_conv_start_n == i_pwm_adc_port_pins[7])
    else $error("conv start");
  AST_CLK_B: assert property (o_pwm_ext_clk_b == i_pwm_adc_port_pins[5])
    else $error("pwm clock");
  AST_CLK_A: assert property (o_pwm_ext_clk_a == i_pwm_adc_port_pins[4])
    else $error("pwm clock a");
  AST_BUS_READ: assert property ((!o_prog_fetch_strobe_n || !o_data_rd_strobe_n) |->
    o_bus_high_port_oe == 8'hff && o_bus_low_port_oe == 8'h00) else $error("bus not turned");
endmodule // port_io_monitor
bind port_io_and_memory_bus port_io_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_sfr_req(i_sfr_req), .o_sfr_rdata(o_sfr_rdata),
  .o_fetch_external(o_fetch_external), .i_force_external_n(i_force_external_n),
  .o_addr_latch_strobe(o_addr_latch_strobe), .o_prog_fetch_strobe_n(o_prog_fetch_strobe_n),
  .i_analog_port_pins(i_analog_port_pins), .o_analog_port_pins(o_analog_port_pins),
  .o_analog_port_pins_oe(o_analog_port_pins_oe), .o_analog_in_ch(o_analog_in_ch),
  .i_pwm_adc_port_pins(i_pwm_adc_port_pins), .o_pwm_adc_port_pins_oe(o_pwm_adc_port_pins_oe),
  .o_data_rd_strobe_n(o_data_rd_strobe_n), .o_bus_low_port_oe(o_bus_low_port_oe),
  .o_bus_high_port_oe(o_bus_high_port_oe), .o_pwm_ext_clk_a(o_pwm_ext_clk_a),
  .o_pwm_ext_clk_b(o_pwm_ext_clk_b), .o_ext_conv_start_n(o_ext_conv_start_n));

// ==== tb/ext_mem_model.sv ====
// external memory on the multiplexed bus
// assumes address on the ports while the latch strobe is high
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_ale,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [7:0] i_lo,
  input  wire logic [7:0] i_hi,
  output logic      [7:0] o_lo
);
  logic [15:0] addr_reg = '0;
  logic [7:0]  idle_reg = 8'h5a;
  logic [7:0]  mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
  always @(posedge i_sys_clk) begin
    idle_reg <= ~idle_reg;
    if (i_ale) addr_reg <= {i_hi, i_lo};
    if (!i_wr_n) mem[addr_reg[7:0] ^ addr_reg[15:8]] <= i_lo;
  end
  // released bus shows a changing pattern
  assign o_lo = i_rd_n ? idle_reg : mem[addr_reg[7:0] ^ addr_reg[15:8]];
endmodule // ext_mem_model

// ==== tb/testbench.sv ====
// self-checking bench for the port and memory bus block
// assumes ext_mem_model on the low and high bus ports
`timescale 1ns/10ps
module testbench;
  import port_io_pkg::*;
  logic clk = 0, rst_n = 0, valid = 0, fx_n = 1;
  sfr_req_s sfr = '0;
  ext_req_s ext = '0;
  logic [15:0] faddr = '0;
  logic [7:0] pv = '0, lo_in, mem_lo, rd, an_pins, lo_out, lo_oe, hi_out, al_oe, pw_out, pw_oe, erd;
  logic [3:0] pch = '0, pen = '0;
  logic [7:0] p1_out, p1_oe, p3_out, p3_oe, cp_out, cp_oe, hi_oe;
  logic ale, fs_n, dr_n, dw_n, ready, ev, fext;
  logic [31:0] lf = 32'h60bd_a622;
  logic [7:0] exp_mem [256];
  int failures = 0, total_checks = 0;
  always #10 clk = ~clk;
  assign lo_in = (lo_oe & lo_out) | (~lo_oe & mem_lo);
  assign an_pins = pv & ~al_oe;
  port_io_and_memory_bus dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_sfr_req(sfr),
    .o_sfr_rdata(rd), .i_ext_req(ext), .i_ext_req_valid(valid), .o_ext_req_ready(ready),
    .o_ext_rdata(erd), .o_ext_rdata_valid(ev), .o_fetch_external(fext),
    .i_fetch_addr(faddr), .i_force_external_n(fx_n), .o_addr_latch_strobe(ale),
    .o_prog_fetch_strobe_n(fs_n), .o_data_rd_strobe_n(dr_n), .o_data_wr_strobe_n(dw_n),
    .i_bus_low_port(lo_in), .o_bus_low_port(lo_out), .o_bus_low_port_oe(lo_oe),
    .i_bus_high_port(pv), .o_bus_high_port(hi_out), .o_bus_high_port_oe(hi_oe),
    .i_port_one(pv), .o_port_one(p1_out), .o_port_one_oe(p1_oe), .i_port_three(pv),
    .o_port_three(p3_out), .o_port_three_oe(p3_oe), .i_compare_port(pv),
    .o_compare_port(cp_out), .o_compare_port_oe(cp_oe),
    .i_analog_port_pins(an_pins), .o_analog_port_pins(), .o_analog_port_pins_oe(al_oe),
    .o_analog_in_ch(), .i_pwm_adc_port_pins(pv), .o_pwm_adc_port_pins(pw_out),
    .o_pwm_adc_port_pins_oe(pw_oe), .i_pwm_out_ch(pch), .i_pwm_out_en(pen),
    .o_pwm_ext_clk_a(), .o_pwm_ext_clk_b(), .o_ext_conv_start_n());
  ext_mem_model u_mem (.i_sys_clk(clk), .i_ale(ale), .i_rd_n(fs_n & dr_n), .i_wr_n(dw_n),
    .i_lo(lo_out), .i_hi(hi_out), .o_lo(mem_lo));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 sfr = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #1 sfr = '0;
  endtask
  task automatic xfer(input logic f, input logic w, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk) #1;
    ext = '{fetch: f, data_wr: w, addr: a, wdata: d};
    valid = 1'b1;
    while (!ready && n < 12) begin
      @(posedge clk) #1;
      n++;
    end
    chk({7'h00, ready}, 8'h01);
    @(posedge clk) #1 valid = 1'b0;
    if (w) exp_mem[a[7:0] ^ a[15:8]] = d;
    else begin
      n = 0;
      while (!ev && n < 12) begin
        @(posedge clk) #1;
        n++;
      end
      chk({7'h00, ev}, 8'h01);
      chk(erd, exp_mem[a[7:0] ^ a[15:8]]);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------
  // main sequence
  // ---------------------------------------
  initial begin
    int lim;
    for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'ha5;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(al_oe, 8'h00);
    acc(1'b0, internal_rom_size_select_addr, 8'h00);
    chk(rd, {5'h00, rom_size_reset});
    for (int k = 0; k < 20; k++) begin
      lf = nxt(lf);
      pv = lf[7:0];
      acc(1'b0, port_one_latch_addr, 8'h00);
      chk(rd, pv);
      acc(1'b0, 8'h81, 8'h00);
      chk(rd, 8'h00);
      acc(1'b1, analog_port_latch_addr, lf[15:8]);
      chk(al_oe, ~lf[15:8]);
      acc(1'b0, analog_port_latch_addr, 8'h00);
      chk(rd, pv & lf[15:8]);
      acc(1'b1, pwm_adc_port_latch_addr, lf[23:16]);
      chk(pw_oe, ~lf[23:16] & 8'hbf);
      acc(1'b0, pwm_adc_port_latch_addr, 8'h00);
      chk(rd, pv & 8'hbf);
      acc(1'b1, port_one_latch_addr, lf[31:24]);
      chk(p1_oe, ~lf[31:24]);
      acc(1'b1, port_three_latch_addr, lf[23:16]);
      chk(p3_oe, ~lf[23:16]);
      acc(1'b1, compare_output_port_latch_addr, lf[15:8]);
      chk(cp_oe, ~lf[15:8]);
      acc(1'b1, bus_high_port_latch_addr, lf[7:0]);
      chk(hi_oe, ~lf[7:0]);
      acc(1'b1, bus_low_port_latch_addr, lf[31:24]);
      chk(lo_oe, ~lf[31:24]);
      chk(p1_out | p3_out | cp_out, 8'h00);
    end
    @(posedge clk) #1 rst_n = 1'b0;
    #1 chk(al_oe | pw_oe | lo_oe, 8'h00);
    @(posedge clk) #1 rst_n = 1'b1;
    for (int c = 0; c < 8; c++) begin
      lim = (c == 0) ? 0 : (c < 5) ? 512 << c : 8192;
      acc(1'b1, internal_rom_size_select_addr, 8'(c));
      faddr = lim[15:0];
      #1 chk({7'h00, fext}, 8'h01);
      @(posedge clk) #1 faddr = 16'(lim - 1);
      #1 chk({7'h00, fext}, {7'h00, c == 0});
    end
    @(posedge clk) #1;
    fx_n = 1'b0;
    faddr = 16'h0000;
    #1 chk({7'h00, fext}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      lf = nxt(lf);
      xfer(1'b0, 1'b1, lf[15:0], lf[23:16]);
      xfer(k[0], 1'b0, lf[15:0], 8'h00);
    end
    @(posedge clk) #1;
    pen = 4'hf;
    pch = lf[3:0];
    #1 chk(pw_out, {4'h0, pch});
    chk(pw_oe & 8'h0f, 8'h0f);
    complete_run();
  end
  initial begin
    #200_000;
    failures++;
    complete_run();
  end
endmodule // testbench
